// >>> sim/lpt_vec_src.sv
`timescale 1ns/100ps
// ============================================================
// Sample memory playback model: one vector per cycle when busy, random stall cycles when slow
// ============================================================
module lpt_vec_src
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic slow,
    input wire logic [23:0] base,
    input wire logic [23:0] len,
    input wire logic [7:0] loops,
    output logic vec_valid,
    output logic [23:0] vec_addr,
    output logic vec_loop,
    output logic busy
);
    logic [23:0] cur;
    logic [23:0] left;
    logic [7:0] lp;

    // Segment playback; idle address inverts so no stale value lingers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            busy <= 1'b0;
            vec_valid <= 1'b0;
            vec_loop <= 1'b0;
            vec_addr <= 24'h00_0000;
        end
        else if (!busy && start)
        begin
            busy <= 1'b1;
            vec_valid <= 1'b1;
            vec_addr <= base;
            vec_loop <= 1'b0;
            cur <= base + 24'h00_0001;
            left <= len - 24'h00_0001;
            lp <= loops;
        end
        else if (!busy || (slow && $urandom_range(1, 0) == 0))
        begin
            vec_valid <= 1'b0; // Stall when slow
            vec_loop <= 1'b0;
            vec_addr <= ~vec_addr;
        end
        else if (left != 24'h00_0000)
        begin
            vec_valid <= 1'b1;
            vec_addr <= cur;
            vec_loop <= 1'b0;
            cur <= cur + 24'h00_0001;
            left <= left - 24'h00_0001;
        end
        else if (lp > 8'h01)
        begin
            vec_valid <= 1'b1;
            vec_addr <= base;
            vec_loop <= 1'b1;
            cur <= base + 24'h00_0001;
            left <= len - 24'h00_0001;
            lp <= lp - 8'h01;
        end
        else
        begin
            busy <= 1'b0;
            vec_valid <= 1'b0;
            vec_loop <= 1'b0;
            vec_addr <= ~vec_addr;
        end
    end
endmodule : lpt_vec_src

// >>> sim/testbench.sv
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the linear playtime checker
// ============================================================
module testbench;
    logic ref_clk, reset, reg_wr, reg_rd, vec_valid, vec_loop, rd_seen;
    logic seg_small, adv_evt, adv_go, linear_met, irq;
    logic src_start, src_slow, src_busy;
    logic [1:0] seg_mode;
    logic [7:0] reg_addr, src_loops;
    logic [23:0] vec_addr, src_base, src_len, ptr, ln;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] seg_base [4];
    int errors, n_tests, cyc, i;
    logic [31:0] rq[$];
    int gq[$];

    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    lpt_checker u_lpt_checker (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .vec_loop(vec_loop), .seg_small(seg_small),
        .seg_mode(seg_mode), .adv_evt(adv_evt), .adv_go(adv_go),
        .linear_met(linear_met), .irq(irq));

    lpt_vec_src u_lpt_vec_src (.ref_clk(ref_clk), .reset(reset),
        .start(src_start), .slow(src_slow), .base(src_base),
        .len(src_len), .loops(src_loops), .vec_valid(vec_valid),
        .vec_addr(vec_addr), .vec_loop(vec_loop), .busy(src_busy));

    // Compare tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task chk_go(input int e, input int g);
        n_tests++;
        if (g != e)
        begin
            errors++;
            $display("mismatch adv_go_cycle expected %0d seen %0d", e, g);
        end
    endtask : chk_go

    task summarize;
        if (gq.size() != 0 || rq.size() != 0)
            errors++;
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Register bus cycles
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask : rd

    // Re-enable clears the run count
    task en;
        wr(lpt_pkg::OFF_CTRL, 32'h0000_0000);
        wr(lpt_pkg::OFF_CTRL, 32'h0000_0001);
    endtask : en

    // Play one segment; ev notes an expected release dly edges on
    task play(input logic [23:0] b, input logic [23:0] l,
              input logic [7:0] lp, input logic sl, input int ev,
              input int dly);
        int k;
        @(posedge ref_clk);
        src_base <= b;
        src_len <= l;
        src_loops <= lp;
        src_slow <= sl;
        src_start <= 1'b1;
        adv_evt <= (ev != 0);
        if (ev != 0)
            gq.push_back(cyc + dly);
        for (k = 0; k < 4000 && (k < 3 || src_busy); k++)
        begin
            @(posedge ref_clk);
            src_start <= 1'b0;
            adv_evt <= (ev == 2 && k == 50); // Extra event while held
        end
        @(posedge ref_clk);
    endtask : play

    // Output watcher: takes the oldest note when a result appears
    always @(posedge ref_clk)
    begin
        if (rd_seen)
            chk("reg_rdata", rq.size() ? rq.pop_front() : 32'hdead_beef,
                reg_rdata);
        rd_seen <= reg_rd;
        if (adv_go === 1'b1)
            chk_go(gq.size() ? gq.pop_front() : -1, cyc);
    end

    // Cycle count and hang limit
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            summarize();
        end
    end

    initial
    begin
        {reg_wr, reg_rd, seg_small, adv_evt, src_start} = '0;
        {src_slow, seg_mode, reg_addr, reg_wdata} = '0;
        {src_base, src_len, src_loops, errors, n_tests} = '0;
        reset = 1'b1;
        void'($urandom(20980));
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0000);
        rd(lpt_pkg::OFF_MASK, 32'h0000_0000);
        rd(lpt_pkg::OFF_RUNCNT, 32'h0000_0000);
        rd(8'h1c, 32'h0000_0000);
        // Placement in write order, random lengths for segments 1 and 2
        wr(lpt_pkg::OFF_CTRL, 32'h0000_0002);
        ptr = 24'h00_0000;
        for (i = 0; i < 4; i++)
        begin
            seg_base[i] = ptr;
            ln = (i == 0) ? 24'h00_012c : 24'(5 + $urandom % 396);
            if (i == 3)
                ln = 24'h00_0005;
            ptr = ptr + ln;
            wr(lpt_pkg::OFF_SEG_SEL, 32'(i));
            wr(lpt_pkg::OFF_SEG_LEN, {8'h00, ln});
            rd(lpt_pkg::OFF_SEG_LEN, {ln >= 24'h00_0101, 7'h00, ptr});
        end
        wr(lpt_pkg::OFF_SEG_LEN, 32'h0000_0004);
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0004);
        rd(lpt_pkg::OFF_SEG_LEN, {8'h00, ptr});
        for (i = 0; i < 4; i++)
        begin
            wr(lpt_pkg::OFF_SEG_SEL, 32'(i));
            rd(lpt_pkg::OFF_SEG_BASE, {8'h00, seg_base[i]});
        end
        wr(lpt_pkg::OFF_STATUS, 32'h0000_0007);
        // Vector stream: loops, placement ahead of big, adjacency
        wr(lpt_pkg::OFF_MASK, 32'h0000_0001);
        en();
        play(24'h00_0100, 24'h00_0081, 8'h02, 1'b0, 0, 0);
        rd(lpt_pkg::OFF_RUNCNT, 32'h0000_0101);
        chk("linear_met", 32'h0000_0001, {31'h0, linear_met});
        play(24'h00_0800, 24'h00_0005, 8'h01, 1'b0, 0, 0);
        play(24'h00_0805, 24'h00_012c, 8'h01, 1'b0, 0, 0);
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0000);
        en();
        play(24'h00_1000, 24'h00_007e, 8'h01, 1'b0, 0, 0);
        play(24'h00_107e, 24'h00_0083, 8'h01, 1'b0, 0, 0);
        play(24'h00_2000, 24'h00_0064, 8'h01, 1'b0, 0, 0);
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0000);
        play(24'h00_3000, 24'h00_000a, 8'h01, 1'b0, 0, 0);
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0001);
        rd(lpt_pkg::OFF_RUNCNT, 32'h0000_000a);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        wr(lpt_pkg::OFF_STATUS, 32'h0000_0001);
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        en();
        play(24'h00_4000, 24'h00_012c, 8'h01, 1'b1, 0, 0);
        rd(lpt_pkg::OFF_RUNCNT, 32'h0000_0101);
        rd(lpt_pkg::OFF_STATUS, 32'h0000_0000);
        // Held release: 257th vector at S+258, seen S+259, out S+260
        seg_small <= 1'b1;
        for (i = 1; i < 4; i++)
        begin
            seg_mode <= 2'(i);
            en();
            play(24'h00_5000, 24'h00_0064, 8'h03, 1'b0, 2, 260);
            rd(lpt_pkg::OFF_STATUS, 32'h0000_0002);
            chk("irq", 32'h0000_0000, {31'h0, irq});
            wr(lpt_pkg::OFF_STATUS, 32'h0000_0002);
        end
        seg_mode <= lpt_pkg::ADV_AUTO;
        en();
        play(24'h00_6000, 24'h00_0064, 8'h01, 1'b0, 1, 2);
        seg_small <= 1'b0;
        seg_mode <= lpt_pkg::ADV_COND;
        en();
        play(24'h00_7000, 24'h00_012c, 8'h01, 1'b0, 1, 2);
        repeat (4) @(posedge ref_clk);
        summarize();
    end
endmodule : testbench

// >>> verilog/lpt_checker.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// R1: Unconstrained segments need at least 257 vectors.
// R2: Segments of 5 to 256 vectors are small.
// R3: 257 ascending vectors must precede any jump.
// R4: Segments placed ascending in write order.
// R5: Loop count multiplies segment length toward run.
// R6: Contiguous small segments add their lengths.
// R7: Short small segments sit before big ones. Not checked here; segments are placed in write order.
// R8: Conditional small segment event held until run.
// R9: Repeat or single small segment event held.
// R10: Any linear run breach sets a status flag.
// R11: Count ascending vectors, restart on address jump.
module lpt_checker
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [lpt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lpt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lpt_pkg::DATA_W-1:0] reg_rdata,
    input wire logic vec_valid,
    input wire logic [lpt_pkg::SADDR_W-1:0] vec_addr,
    input wire logic vec_loop,
    input wire logic seg_small,
    input wire logic [1:0] seg_mode,
    input wire logic adv_evt,
    output logic adv_go,
    output logic linear_met,
    output logic irq
);

    // ============================================================
    // Declarations
    // ============================================================
    logic enable_q, started_q, big_q, adv_go_q, go_d, linear_met_q, irq_q;
    logic [lpt_pkg::SADDR_W-1:0] prev_addr_q, next_free_q, seg_base;
    logic [lpt_pkg::SADDR_W-1:0] wr_len_val;
    logic [lpt_pkg::RUN_W-1:0] run_q, run_d;
    logic [lpt_pkg::ST_W-1:0] status_q, status_d, status_set, status_clr;
    logic [lpt_pkg::ST_W-1:0] mask_q;
    logic [lpt_pkg::SEG_IDX_W-1:0] sel_q;
    lpt_pkg::lpt_gate_e state_q, state_d;
    logic [lpt_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic seq_next, jump, viol_evt, met_now, need_hold, held_evt;
    logic wr_ctrl, wr_status, wr_mask, wr_sel, wr_len, len_ok, len_err;

    // Assertions below share one clock and reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ============================================================
    // Register decode
    // ============================================================
    function automatic logic hit(input logic [lpt_pkg::ADDR_W-1:0] a,
                                 input logic [lpt_pkg::ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // Write strobes per register
    assign wr_ctrl = reg_wr && hit(reg_addr, lpt_pkg::OFF_CTRL);
    assign wr_status = reg_wr && hit(reg_addr, lpt_pkg::OFF_STATUS);
    assign wr_mask = reg_wr && hit(reg_addr, lpt_pkg::OFF_MASK);
    assign wr_sel = reg_wr && hit(reg_addr, lpt_pkg::OFF_SEG_SEL);
    assign wr_len = reg_wr && hit(reg_addr, lpt_pkg::OFF_SEG_LEN);
    assign wr_len_val = reg_wdata[lpt_pkg::SADDR_W-1:0];
    assign len_err = wr_len && (wr_len_val < lpt_pkg::SMALL_MIN); // R2
    assign len_ok = wr_len && !len_err;

    // Enable bit
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            enable_q <= 1'b0;
        else if (wr_ctrl)
            enable_q <= reg_wdata[lpt_pkg::CTRL_EN];
    end

    // Mask and segment select
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            mask_q <= lpt_pkg::MASK_RESET;
            sel_q <= '0;
        end
        else
        begin
            if (wr_mask)
                mask_q <= reg_wdata[lpt_pkg::ST_W-1:0];
            if (wr_sel)
                sel_q <= reg_wdata[lpt_pkg::SEG_IDX_W-1:0];
        end
    end

    // ============================================================
    // Segment placement
    // ============================================================
    // Allocation pointer, cleared memory restarts at zero
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            next_free_q <= lpt_pkg::FREE_RESET;
            big_q <= 1'b0;
        end
        else if (wr_ctrl && reg_wdata[lpt_pkg::CTRL_CLR])
        begin
            next_free_q <= lpt_pkg::FREE_RESET; // R4
            big_q <= 1'b0;
        end
        else if (len_ok)
        begin
            next_free_q <= next_free_q + wr_len_val; // R4
            big_q <= (wr_len_val >= lpt_pkg::BIG_MIN); // R1
        end
    end

    // Base addresses of placed segments
    lpt_seg_mem u_seg_mem
    (
        .ref_clk(ref_clk),
        .wr_en(len_ok),
        .wr_idx(sel_q),
        .wr_data(next_free_q),
        .rd_idx(sel_q),
        .rd_data(seg_base)
    );

    // ============================================================
    // Linear run counter
    // ============================================================
    assign seq_next = (vec_addr == prev_addr_q + lpt_pkg::SADDR_ONE);
    // Loop restarts keep the run going
    assign jump = enable_q && vec_valid && started_q && !seq_next
        && !vec_loop; // R11
    assign viol_evt = jump && (run_q < lpt_pkg::RUN_MIN); // R3
    assign met_now = (run_q >= lpt_pkg::RUN_MIN);

    // Next run count, saturating at the threshold
    always_comb
    begin
        run_d = run_q;
        if (!enable_q)
            run_d = '0;
        else if (vec_valid)
        begin
            if (!started_q || jump)
                run_d = lpt_pkg::RUN_ONE; // R11
            else if (run_q < lpt_pkg::RUN_MIN)
                run_d = run_q + lpt_pkg::RUN_ONE; // R5 R6
        end
    end

    // Run state
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            run_q <= '0;
            started_q <= 1'b0;
            prev_addr_q <= '0;
            linear_met_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            linear_met_q <= (run_d >= lpt_pkg::RUN_MIN);
            if (!enable_q)
                started_q <= 1'b0;
            else if (vec_valid)
            begin
                started_q <= 1'b1;
                prev_addr_q <= vec_addr;
            end
        end
    end

    // ============================================================
    // Advancement gate
    // ============================================================
    // Non-auto small segments wait for a full run
    assign need_hold = seg_small
        && (seg_mode != lpt_pkg::ADV_AUTO); // R8 R9
    assign held_evt = (state_q == lpt_pkg::GATE_IDLE) && adv_evt
        && need_hold && !met_now;

    // Gate next state and release pulse
    always_comb
    begin
        state_d = state_q;
        go_d = 1'b0;
        case (state_q)
            lpt_pkg::GATE_IDLE:
                if (adv_evt && enable_q)
                begin
                    if (need_hold && !met_now)
                        state_d = lpt_pkg::GATE_HOLD; // R8 R9
                    else
                        go_d = 1'b1;
                end
            lpt_pkg::GATE_HOLD:
                if (!enable_q)
                    state_d = lpt_pkg::GATE_IDLE;
                else if (met_now)
                begin
                    state_d = lpt_pkg::GATE_IDLE; // R8 R9
                    go_d = 1'b1;
                end
            default:
                state_d = lpt_pkg::GATE_IDLE;
        endcase
    end

    // Gate registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= lpt_pkg::GATE_IDLE;
            adv_go_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            adv_go_q <= go_d;
        end
    end

    // ============================================================
    // Status, mask and interrupt
    // ============================================================
    assign status_set = {len_err, held_evt && enable_q, viol_evt}; // R10
    assign status_clr = wr_status ? reg_wdata[lpt_pkg::ST_W-1:0] : '0;
    // Set wins over a simultaneous clear
    assign status_d = (status_q & ~status_clr) | status_set;

    // Sticky status and interrupt level
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            status_q <= lpt_pkg::ST_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d; // R10
            irq_q <= |(status_d & mask_q);
        end
    end

    // ============================================================
    // Read path
    // ============================================================
    always_comb
    begin
        rdata_d = '0;
        if (hit(reg_addr, lpt_pkg::OFF_CTRL))
            rdata_d[lpt_pkg::CTRL_EN] = enable_q;
        else if (hit(reg_addr, lpt_pkg::OFF_STATUS))
            rdata_d[lpt_pkg::ST_W-1:0] = status_q;
        else if (hit(reg_addr, lpt_pkg::OFF_MASK))
            rdata_d[lpt_pkg::ST_W-1:0] = mask_q;
        else if (hit(reg_addr, lpt_pkg::OFF_RUNCNT))
            rdata_d[lpt_pkg::RUN_W-1:0] = run_q;
        else if (hit(reg_addr, lpt_pkg::OFF_SEG_SEL))
            rdata_d[lpt_pkg::SEG_IDX_W-1:0] = sel_q;
        else if (hit(reg_addr, lpt_pkg::OFF_SEG_LEN))
        begin
            rdata_d[lpt_pkg::SADDR_W-1:0] = next_free_q;
            rdata_d[lpt_pkg::SEG_BIG_BIT] = big_q;
        end
        else if (hit(reg_addr, lpt_pkg::OFF_SEG_BASE))
            rdata_d[lpt_pkg::SADDR_W-1:0] = seg_base;
    end

    // Read data register, zero outside a read answer
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            rdata_q <= '0;
        else
            rdata_q <= reg_rd ? rdata_d : '0;
    end

    assign reg_rdata = rdata_q;
    assign adv_go = adv_go_q;
    assign linear_met = linear_met_q;
    assign irq = irq_q;

    // ============================================================
    // Assertions
    // ============================================================
    sequence s_held;
        (state_q == lpt_pkg::GATE_HOLD) && !adv_go_q;
    endsequence

    sequence s_release;
        enable_q && met_now;
    endsequence

    run_restart_a: assert property (jump |=> run_q == 9'h001) // R11
        else $error("run count not restarted on jump");
    run_step_a: assert property (enable_q && vec_valid && started_q // R6
        && seq_next && (run_q < lpt_pkg::RUN_MIN)
        |=> run_q == $past(run_q) + 9'h001)
        else $error("run count did not advance");
    loop_keep_a: assert property (enable_q && vec_valid && started_q // R5
        && vec_loop && !seq_next && (run_q < lpt_pkg::RUN_MIN)
        |=> run_q == $past(run_q) + 9'h001)
        else $error("loop restart broke the run");
    viol_flag_a: assert property (viol_evt // R10
        |=> status_q[lpt_pkg::ST_VIOL])
        else $error("violation not flagged");
    event_hold_a: assert property (enable_q && held_evt |=> s_held) // R8
        else $error("advancement event not held");
    hold_release_a: assert property (s_held ##0 s_release // R9
        |=> adv_go_q && (state_q == lpt_pkg::GATE_IDLE))
        else $error("held event not released at run");
    hold_wait_a: assert property (s_held ##0 (enable_q && !met_now) // R8 R9
        |=> !adv_go_q)
        else $error("event released before full run");
    seg_place_a: assert property (len_ok && !wr_ctrl // R4
        |=> next_free_q == $past(next_free_q) + $past(wr_len_val))
        else $error("segment not placed after previous");
    len_check_a: assert property (len_err // R2
        |=> status_q[lpt_pkg::ST_LENERR] && $stable(next_free_q))
        else $error("short segment accepted");
    irq_level_a: assert property ((|(status_q & mask_q)) // R10
        ##1 $stable(status_q) |-> irq_q)
        else $error("interrupt missing for unmasked status");

endmodule : lpt_checker

// >>> verilog/lpt_pkg.sv
// ============================================================
// Shared constants for the linear playtime checker
// ============================================================
package lpt_pkg;

    // Widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SADDR_W = 24;
    localparam int RUN_W = 9;
    localparam int SEG_IDX_W = 4;
    localparam int SEG_DEPTH = 16;
    localparam int ST_W = 3;

    // Linear run thresholds in sample vectors
    localparam logic [RUN_W-1:0] RUN_MIN = 9'h101;
    localparam logic [RUN_W-1:0] RUN_ONE = 9'h001;
    localparam logic [SADDR_W-1:0] SMALL_MIN = 24'h00_0005;
    localparam logic [SADDR_W-1:0] BIG_MIN = 24'h00_0101;
    localparam logic [SADDR_W-1:0] SADDR_ONE = 24'h00_0001;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_RUNCNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_SEG_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SEG_LEN = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SEG_BASE = 8'h18;

    // Control bits and segment length big flag bit
    localparam int CTRL_EN = 0;
    localparam int CTRL_CLR = 1;
    localparam int SEG_BIG_BIT = 31;

    // Status and mask bits
    localparam int ST_VIOL = 0;
    localparam int ST_HELD = 1;
    localparam int ST_LENERR = 2;

    // Reset values
    localparam logic [ST_W-1:0] ST_RESET = 3'h0;
    localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
    localparam logic [SADDR_W-1:0] FREE_RESET = 24'h00_0000;

    // Advancement mode of the segment being played
    typedef enum logic [1:0] {
        ADV_AUTO = 2'b00,
        ADV_COND = 2'b01,
        ADV_REPEAT = 2'b10,
        ADV_SINGLE = 2'b11
    } lpt_adv_e;

    // Advancement gate states
    typedef enum logic [0:0] {
        GATE_IDLE = 1'b0,
        GATE_HOLD = 1'b1
    } lpt_gate_e;

endpackage : lpt_pkg

// >>> verilog/lpt_seg_mem.sv
`timescale 1ns/100ps
// ============================================================
// Segment base address table, registered read, read-first
// ============================================================
module lpt_seg_mem
(
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [lpt_pkg::SEG_IDX_W-1:0] wr_idx,
    input wire logic [lpt_pkg::SADDR_W-1:0] wr_data,
    input wire logic [lpt_pkg::SEG_IDX_W-1:0] rd_idx,
    output logic [lpt_pkg::SADDR_W-1:0] rd_data
);

    logic [lpt_pkg::SADDR_W-1:0] mem [lpt_pkg::SEG_DEPTH];

    // Storage write
    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Registered read of the selected entry
    always_ff @(posedge ref_clk)
    begin
        rd_data <= mem[rd_idx];
    end

endmodule : lpt_seg_mem
